// File: core/pmtr_pkg.sv
// Shared constants for the program memory and table read unit
package pmtr_pkg;

   // Program memory geometry defaults
   localparam int PM_ADDR_W      = 12;
   localparam int PM_WORD_W      = 16;
   localparam int PM_ADDR_W_MIN  = 9;
   localparam int RESET_VECTOR   = 'h000;
   localparam int BYTE_W         = 8;

   // Serial programming frame layout, command bits sent first
   localparam int ICP_CMD_W      = 2;
   localparam int ICP_ADDR_W     = 12;
   localparam int ICP_DATA_W     = 16;
   localparam int ICP_HDR_BITS   = ICP_CMD_W + ICP_ADDR_W;
   localparam int ICP_FRAME_BITS = ICP_HDR_BITS + ICP_DATA_W;
   localparam int ICP_CNT_W      = 5;
   localparam int ICP_IDX_W      = 4;

   // Internal phases of one instruction cycle
   typedef enum logic [1:0] {
      PH_T1 = 2'b00,
      PH_T2 = 2'b01,
      PH_T3 = 2'b10,
      PH_T4 = 2'b11
   } pmtr_phase_e;

   // Table read addressing flavours
   typedef enum logic {
      TAB_PAGE = 1'b0,
      TAB_LAST = 1'b1
   } pmtr_tab_e;

   // Serial programming commands
   typedef enum logic [1:0] {
      ICP_PM_WR = 2'b00,
      ICP_EE_WR = 2'b01,
      ICP_PM_RD = 2'b10,
      ICP_NOP   = 2'b11
   } pmtr_icp_cmd_e;

endpackage

// File: core/pmtr_prog_mem.sv
`timescale 1ns/1ns
`default_nettype none
// Flip-flop program store, one write port and two read ports
module pmtr_prog_mem #(
   parameter int ADDR_W = pmtr_pkg::PM_ADDR_W,
   parameter int WORD_W = pmtr_pkg::PM_WORD_W
) (
   input  wire logic              core_clk,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [WORD_W-1:0] wr_data,
   input  wire logic [ADDR_W-1:0] rd_a_addr,
   output logic      [WORD_W-1:0] rd_a_data,
   input  wire logic [ADDR_W-1:0] rd_b_addr,
   output logic      [WORD_W-1:0] rd_b_data
);
   import pmtr_pkg::*;

   logic [WORD_W-1:0] mem_ff [2**ADDR_W];

   // Storage written only by the programming port
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem_ff[wr_addr] <= wr_data;
      end
   end

   // Indexed reads
   assign rd_a_data = mem_ff[rd_a_addr];
   assign rd_b_data = mem_ff[rd_b_addr];
endmodule
`default_nettype wire

// File: core/pmtr_top.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Reset loads program counter with zero
// - Words of WORD_W bits, fetched at PC
// - Table address joins low pointer with high pointer, or with all-ones last page
// - Low table byte written to data register
// - High table byte loaded into latch
// - Unimplemented latch bits read as zero
// - Page read: low pointer offsets high page
// - Table instructions last two instruction cycles
// - Latch changes only on table reads
// - Serial data shares one pin, separate clock
// - Serial port writes program and EEPROM
// - Four phases form one instruction cycle
module pmtr_top #(
   parameter int ADDR_W = pmtr_pkg::PM_ADDR_W,
   parameter int WORD_W = pmtr_pkg::PM_WORD_W
) (
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       pc_load,
   input  wire logic [ADDR_W-1:0]          pc_load_addr,
   input  wire logic                       tab_req,
   input  wire pmtr_pkg::pmtr_tab_e        tab_mode,
   input  wire logic [pmtr_pkg::BYTE_W-1:0] tab_dest,
   input  wire logic [pmtr_pkg::BYTE_W-1:0] tblp,
   input  wire logic [pmtr_pkg::BYTE_W-1:0] tbhp,
   output pmtr_pkg::pmtr_phase_e           cycle_phase,
   output logic      [ADDR_W-1:0]          fetch_pc,
   output logic      [WORD_W-1:0]          instr_word,
   output logic                            table_busy,
   output logic                            dm_wr_en,
   output logic      [pmtr_pkg::BYTE_W-1:0] dm_wr_addr,
   output logic      [pmtr_pkg::BYTE_W-1:0] dm_wr_data,
   output logic      [pmtr_pkg::BYTE_W-1:0] table_high_byte_latch,
   input  wire logic                       prog_mode,
   input  wire logic                       prog_serial_clock_pin,
   input  wire logic                       prog_serial_data_pin_in,
   output logic                            prog_serial_data_pin_out,
   output logic                            prog_serial_data_pin_oe,
   output logic                            ee_wr_en,
   output logic      [pmtr_pkg::ICP_ADDR_W-1:0] ee_wr_addr,
   output logic      [pmtr_pkg::BYTE_W-1:0] ee_wr_data
);
   import pmtr_pkg::*;

   // Elaboration check of geometry
   if (ADDR_W < PM_ADDR_W_MIN || ADDR_W > ICP_ADDR_W || WORD_W <= BYTE_W || WORD_W > ICP_DATA_W) begin : g_chk
      $error("pmtr_top: unsupported ADDR_W or WORD_W");
   end

   localparam int PAGE_W = ADDR_W - BYTE_W;

   pmtr_phase_e               phase_ff;
   logic [ADDR_W-1:0]         pc_ff;
   logic [WORD_W-1:0]         instr_ff;
   logic                      busy_ff;
   logic                      tab_cyc_ff;
   logic [ADDR_W-1:0]         tab_addr_ff;
   logic [BYTE_W-1:0]         tab_dest_ff;
   logic                      dm_wr_en_ff;
   logic [BYTE_W-1:0]         dm_wr_data_ff;
   logic [BYTE_W-1:0]         latch_ff;
   logic [ADDR_W-1:0]         nxt_tab_addr;
   logic [WORD_W-1:0]         rd_a_data;
   logic [WORD_W-1:0]         rd_b_data;
   logic [ADDR_W-1:0]         rd_b_addr;
   logic                      tab_start;
   // Serial programming state
   logic                      sclk_q_ff;
   logic                      sclk_rise;
   logic [ICP_CNT_W-1:0]      bit_cnt_ff;
   logic [ICP_HDR_BITS-1:0]   hdr_ff;
   logic [ICP_DATA_W-1:0]     sdata_ff;
   logic [ICP_DATA_W-1:0]     nxt_sdata;
   logic                      sout_ff;
   logic                      soe_ff;
   logic                      pm_wr_en_ff;
   logic [ADDR_W-1:0]         pm_wr_addr_ff;
   logic [WORD_W-1:0]         pm_wr_data_ff;
   logic                      ee_wr_en_ff;
   logic [ICP_ADDR_W-1:0]     ee_wr_addr_ff;
   logic [BYTE_W-1:0]         ee_wr_data_ff;
   pmtr_icp_cmd_e             icp_cmd;
   logic [ICP_ADDR_W-1:0]     icp_addr;
   logic [ICP_DATA_W-1:0]     icp_word;
   logic [ICP_IDX_W-1:0]      data_idx;
   logic                      in_data;

   // Program store
   pmtr_prog_mem #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) u_mem (
      .core_clk  (core_clk),
      .wr_en     (pm_wr_en_ff),
      .wr_addr   (pm_wr_addr_ff),
      .wr_data   (pm_wr_data_ff),
      .rd_a_addr (pc_ff),
      .rd_a_data (rd_a_data),
      .rd_b_addr (rd_b_addr),
      .rd_b_data (rd_b_data)
   );

   // Four phase sequencer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phase_ff <= PH_T1;
      end else begin
         unique case (phase_ff)
            PH_T1: phase_ff <= PH_T2;
            PH_T2: phase_ff <= PH_T3;
            PH_T3: phase_ff <= PH_T4;
            PH_T4: phase_ff <= PH_T1;
         endcase
      end
   end

   // Program counter: fetch at T1, jumps taken at T4
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pc_ff <= ADDR_W'(RESET_VECTOR);
      end else if (phase_ff == PH_T1 && !busy_ff) begin
         pc_ff <= pc_ff + 1'b1;
      end else if (phase_ff == PH_T4 && pc_load && !busy_ff) begin
         pc_ff <= pc_load_addr;
      end
   end

   // Instruction word register, held during table second cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         instr_ff <= '0;
      end else if (phase_ff == PH_T1 && !busy_ff) begin
         instr_ff <= rd_a_data;
      end
   end

   // Table address forming
   assign tab_start = (phase_ff == PH_T2) && tab_req && !busy_ff;
   always_comb begin
      if (tab_mode == TAB_LAST) begin
         nxt_tab_addr = {{PAGE_W{1'b1}}, tblp};
      end else begin
         nxt_tab_addr = {tbhp[PAGE_W-1:0], tblp};
      end
   end

   // Table sequencing over two instruction cycles
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busy_ff     <= 1'b0;
         tab_cyc_ff  <= 1'b0;
         tab_addr_ff <= '0;
         tab_dest_ff <= '0;
      end else if (tab_start) begin
         busy_ff     <= 1'b1;
         tab_addr_ff <= nxt_tab_addr;
         tab_dest_ff <= tab_dest;
      end else if (busy_ff && phase_ff == PH_T1) begin
         tab_cyc_ff  <= 1'b1;
      end else if (tab_cyc_ff && phase_ff == PH_T4) begin
         busy_ff     <= 1'b0;
         tab_cyc_ff  <= 1'b0;
      end
   end

   // Table data transfer at T3 of second cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dm_wr_en_ff   <= 1'b0;
         dm_wr_data_ff <= '0;
         latch_ff      <= '0;
      end else begin
         dm_wr_en_ff <= tab_cyc_ff && phase_ff == PH_T3;
         if (tab_cyc_ff && phase_ff == PH_T3) begin
            dm_wr_data_ff <= rd_b_data[BYTE_W-1:0];
            latch_ff      <= BYTE_W'(rd_b_data[WORD_W-1:BYTE_W]);
         end
      end
   end

   assign rd_b_addr = prog_mode ? icp_addr[ADDR_W-1:0] : tab_addr_ff;

   // Serial frame decode
   assign sclk_rise = prog_serial_clock_pin && !sclk_q_ff;
   assign icp_cmd   = pmtr_icp_cmd_e'(hdr_ff[ICP_HDR_BITS-1 -: ICP_CMD_W]);
   assign icp_addr  = hdr_ff[ICP_ADDR_W-1:0];
   assign in_data   = bit_cnt_ff >= ICP_CNT_W'(ICP_HDR_BITS);
   assign nxt_sdata = {sdata_ff[ICP_DATA_W-2:0], prog_serial_data_pin_in};
   assign icp_word  = ICP_DATA_W'(rd_b_data);
   assign data_idx  = ICP_IDX_W'(ICP_FRAME_BITS - 1 - int'(bit_cnt_ff));

   // Serial shift and commit on programming clock rises
   always_ff @(posedge core_clk) begin
      if (sys_rst || !prog_mode) begin
         sclk_q_ff     <= 1'b0;
         bit_cnt_ff    <= '0;
         hdr_ff        <= '0;
         sdata_ff      <= '0;
         pm_wr_en_ff   <= 1'b0;
         pm_wr_addr_ff <= '0;
         pm_wr_data_ff <= '0;
         ee_wr_en_ff   <= 1'b0;
         ee_wr_addr_ff <= '0;
         ee_wr_data_ff <= '0;
      end else begin
         sclk_q_ff   <= prog_serial_clock_pin;
         pm_wr_en_ff <= 1'b0;
         ee_wr_en_ff <= 1'b0;
         if (sclk_rise) begin
            if (!in_data) begin
               hdr_ff <= {hdr_ff[ICP_HDR_BITS-2:0], prog_serial_data_pin_in};
            end else begin
               sdata_ff <= nxt_sdata;
            end
            if (bit_cnt_ff == ICP_CNT_W'(ICP_FRAME_BITS - 1)) begin
               bit_cnt_ff    <= '0;
               pm_wr_en_ff   <= icp_cmd == ICP_PM_WR;
               pm_wr_addr_ff <= icp_addr[ADDR_W-1:0];
               pm_wr_data_ff <= nxt_sdata[WORD_W-1:0];
               ee_wr_en_ff   <= icp_cmd == ICP_EE_WR;
               ee_wr_addr_ff <= icp_addr;
               ee_wr_data_ff <= nxt_sdata[BYTE_W-1:0];
            end else begin
               bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end
         end
      end
   end

   // Readback driver on the shared data pin
   always_ff @(posedge core_clk) begin
      if (sys_rst || !prog_mode) begin
         sout_ff <= 1'b0;
         soe_ff  <= 1'b0;
      end else begin
         soe_ff  <= in_data && icp_cmd == ICP_PM_RD;
         sout_ff <= icp_word[data_idx];
      end
   end

   // Outputs
   assign cycle_phase              = phase_ff;
   assign fetch_pc                 = pc_ff;
   assign instr_word               = instr_ff;
   assign table_busy               = busy_ff;
   assign dm_wr_en                 = dm_wr_en_ff;
   assign dm_wr_addr               = tab_dest_ff;
   assign dm_wr_data               = dm_wr_data_ff;
   assign table_high_byte_latch    = latch_ff;
   assign prog_serial_data_pin_out = sout_ff;
   assign prog_serial_data_pin_oe  = soe_ff && prog_mode;
   assign ee_wr_en                 = ee_wr_en_ff;
   assign ee_wr_addr               = ee_wr_addr_ff;
   assign ee_wr_data               = ee_wr_data_ff;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_tab_issue;
      tab_start;
   endsequence
   sequence s_tab_finish;
      (!dm_wr_en_ff && busy_ff) [*5] ##1 (dm_wr_en_ff && busy_ff) ##1 !busy_ff;
   endsequence

   a_reset_pc_zero: assert property (disable iff (1'b0) sys_rst |=> pc_ff == ADDR_W'(RESET_VECTOR))
      else $error("pc not at reset vector after reset");
   a_phase_walk: assert property ((phase_ff == PH_T1) |=> phase_ff == PH_T2 ##1 phase_ff == PH_T3 ##1 phase_ff == PH_T4 ##1 phase_ff == PH_T1)
      else $error("phase order broken");
   a_pc_step: assert property ((phase_ff == PH_T1 && !busy_ff) |=> pc_ff == ADDR_W'($past(pc_ff) + 1'b1))
      else $error("pc did not step at fetch");
   a_table_two_cyc: assert property (s_tab_issue |=> s_tab_finish)
      else $error("table read not two instruction cycles");
   a_page_addr: assert property ((tab_start && tab_mode == TAB_PAGE) |=> tab_addr_ff == {$past(tbhp[PAGE_W-1:0]), $past(tblp)})
      else $error("page relative table address wrong");
   a_last_page: assert property ((tab_start && tab_mode == TAB_LAST) |=> (&tab_addr_ff[ADDR_W-1:BYTE_W]) && tab_addr_ff[BYTE_W-1:0] == $past(tblp))
      else $error("last page table address wrong");
   a_low_byte: assert property ((dm_wr_en_ff && !$past(prog_mode)) |-> dm_wr_data_ff == $past(rd_b_data[BYTE_W-1:0]) && dm_wr_addr == $past(tab_dest, 6))
      else $error("table low byte not written");
   a_latch_source: assert property ((dm_wr_en_ff && !$past(prog_mode)) |-> latch_ff == BYTE_W'($past(rd_b_data[WORD_W-1:BYTE_W])))
      else $error("latch not loaded with high byte");
   a_latch_hold: assert property (!$stable(latch_ff) |-> $past(tab_cyc_ff) && $past(phase_ff) == PH_T3)
      else $error("latch changed outside table read");
   a_pin_drive: assert property (prog_serial_data_pin_oe |-> prog_mode && $past(icp_cmd) == ICP_PM_RD)
      else $error("data pin driven outside readback");
   a_ee_pulse: assert property (ee_wr_en_ff |=> !ee_wr_en_ff)
      else $error("eeprom write not a single pulse");
endmodule
`default_nettype wire

// File: dv/pmtr_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
// Serial programmer on the far side of the programming pins
module pmtr_prog_model (
   input  wire logic core_clk,
   input  wire logic pin_level,
   output logic      clk_pin,
   output logic      data_out
);
   // One 30-bit frame, MSB first, gathering readback bits
   task automatic send_frame(input logic [1:0] cmd, input logic [11:0] addr,
                             input logic [15:0] data, output logic [15:0] rd);
      logic [29:0] frame;
      frame = {cmd, addr, data};
      rd = 16'h0000;
      for (int k = 1; k <= 30; k++) begin
         @(negedge core_clk);
         if (k > 14 && cmd == 2'b10) begin
            data_out = ~data_out; // Released line shows no stale level
         end else begin
            data_out = frame[30-k]; // Command, address, data
         end
         @(negedge core_clk);
         if (k > 14) begin
            rd = {rd[14:0], pin_level};
         end
         @(negedge core_clk);
         clk_pin = 1'b1;
         repeat (2) @(negedge core_clk);
         clk_pin = 1'b0; // Clock rests low between frames
      end
      repeat (4) @(negedge core_clk);
   endtask

   // Idle levels
   initial begin
      clk_pin = 1'b0;
      data_out = 1'b0;
   end
endmodule
`default_nettype wire

// File: dv/pmtr_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module pmtr_top_bench;
   import pmtr_pkg::*;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        pc_load = 1'b0;
   logic [11:0] pc_load_addr = 12'h000;
   logic        tab_req = 1'b0;
   pmtr_tab_e   tab_mode = TAB_PAGE;
   logic [7:0]  tab_dest = 8'h00;
   logic [7:0]  tblp = 8'h00;
   logic [7:0]  tbhp = 8'h00;
   pmtr_phase_e cycle_phase;
   logic [11:0] fetch_pc;
   logic [15:0] instr_word;
   logic        table_busy;
   logic        dm_wr_en;
   logic [7:0]  dm_wr_addr;
   logic [7:0]  dm_wr_data;
   logic [7:0]  table_high_byte_latch;
   logic        prog_mode = 1'b1;
   logic        ser_clk;
   logic        m_out;
   wire         pin_in;
   logic        pin_out;
   logic        pin_oe;
   logic        ee_wr_en;
   logic [11:0] ee_wr_addr;
   logic [7:0]  ee_wr_data;
   logic [11:0] ee_a;
   logic [7:0]  ee_d;
   int          ee_cnt = 0;
   int          fail_count = 0;
   int          n_tests = 0;
   logic [11:0] pm_a [4] = '{12'h010, 12'h305, 12'hF05, 12'hF06};
   logic [15:0] pm_w [4] = '{16'hC3E1, 16'h7E81, 16'h000F, 16'h001A};

   // Clock and resolved data pin
   always #5 core_clk = ~core_clk;
   assign pin_in = pin_oe ? pin_out : m_out;

   // Catch one-cycle EEPROM write pulses
   always @(posedge core_clk) begin
      if (ee_wr_en === 1'b1) begin
         ee_cnt <= ee_cnt + 1;
         ee_a <= ee_wr_addr;
         ee_d <= ee_wr_data;
      end
   end

   pmtr_top u_pmtr_top (.core_clk(core_clk), .sys_rst(sys_rst), .pc_load(pc_load),
      .pc_load_addr(pc_load_addr), .tab_req(tab_req), .tab_mode(tab_mode), .tab_dest(tab_dest),
      .tblp(tblp), .tbhp(tbhp), .cycle_phase(cycle_phase), .fetch_pc(fetch_pc),
      .instr_word(instr_word), .table_busy(table_busy), .dm_wr_en(dm_wr_en),
      .dm_wr_addr(dm_wr_addr), .dm_wr_data(dm_wr_data),
      .table_high_byte_latch(table_high_byte_latch), .prog_mode(prog_mode),
      .prog_serial_clock_pin(ser_clk), .prog_serial_data_pin_in(pin_in),
      .prog_serial_data_pin_out(pin_out), .prog_serial_data_pin_oe(pin_oe),
      .ee_wr_en(ee_wr_en), .ee_wr_addr(ee_wr_addr), .ee_wr_data(ee_wr_data));

   pmtr_prog_model u_pmtr_prog_model (.core_clk(core_clk), .pin_level(pin_in),
      .clk_pin(ser_clk), .data_out(m_out));

   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic test_done;
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Reset vector, then four phases per instruction cycle
   task automatic t_reset;
      logic [1:0] p;
      repeat (12) @(negedge core_clk);
      check("pc in reset", 16'h0000, {4'h0, fetch_pc});
      check("phase in reset", 16'h0000, {14'h0, cycle_phase});
      sys_rst = 1'b0;
      @(negedge core_clk);
      check("pc after first fetch", 16'h0001, {4'h0, fetch_pc});
      p = cycle_phase;
      repeat (7) begin
         @(negedge core_clk);
         p = p + 2'b01;
         check("phase order", {14'h0, p}, {14'h0, cycle_phase});
      end
   endtask

   // Serial writes to program memory, readback, then EEPROM write and NOP
   task automatic t_serial;
      logic [15:0] rd;
      for (int i = 0; i < 4; i++)
         u_pmtr_prog_model.send_frame(ICP_PM_WR, pm_a[i], pm_w[i], rd);
      u_pmtr_prog_model.send_frame(ICP_PM_RD, 12'h305, 16'h0000, rd);
      check("serial readback", 16'h7E81, rd);
      u_pmtr_prog_model.send_frame(ICP_EE_WR, 12'hA5C, 16'h3C96, rd);
      check("eeprom writes", 16'h0001, ee_cnt[15:0]);
      check("eeprom addr", 16'h0A5C, {4'h0, ee_a});
      check("eeprom data", 16'h0096, {8'h00, ee_d});
      u_pmtr_prog_model.send_frame(ICP_NOP, 12'hA5C, 16'h3C96, rd);
      check("eeprom after nop", 16'h0001, ee_cnt[15:0]);
      @(negedge core_clk);
      prog_mode = 1'b0;
      @(negedge core_clk);
      check("pin released", 16'h0000, {15'h0, pin_oe});
   endtask

   // Jump and fetch; the latch must not move
   task automatic t_fetch(input logic [11:0] a, input logic [15:0] w, input logic [7:0] lat);
      @(negedge core_clk);
      while (cycle_phase !== PH_T4 || table_busy !== 1'b0) @(negedge core_clk);
      pc_load = 1'b1;
      pc_load_addr = a;
      @(negedge core_clk);
      pc_load = 1'b0;
      @(negedge core_clk);
      check("fetched word", w, instr_word);
      check("pc after fetch", {4'h0, a + 12'h001}, {4'h0, fetch_pc});
      check("latch unchanged", {8'h00, lat}, {8'h00, table_high_byte_latch});
   endtask

   // Table read with decoy requests held during busy
   task automatic t_table(input pmtr_tab_e md, input logic [7:0] hp, input logic [7:0] lp,
                          input logic [7:0] dest, input logic [15:0] w);
      int n;
      @(negedge core_clk);
      while (cycle_phase !== PH_T2 || table_busy !== 1'b0) @(negedge core_clk);
      tab_req = 1'b1;
      tab_mode = md;
      tbhp = hp;
      tblp = lp;
      tab_dest = dest;
      @(negedge core_clk);
      tbhp = ~hp;
      tblp = ~lp;
      tab_dest = ~dest;
      n = 1;
      while (dm_wr_en !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      tab_req = 1'b0;
      check("table latency", 16'h0006, n[15:0]);
      check("dm addr", {8'h00, dest}, {8'h00, dm_wr_addr});
      check("dm data", {8'h00, w[7:0]}, {8'h00, dm_wr_data});
      check("latch", {8'h00, w[15:8]}, {8'h00, table_high_byte_latch});
      @(negedge core_clk);
      check("busy end", 16'h0000, {15'h0, table_busy});
      check("dm pulse end", 16'h0000, {15'h0, dm_wr_en});
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      test_done();
   end

   // Main sequence
   initial begin
      t_reset();
      t_serial();
      t_fetch(12'h010, 16'hC3E1, 8'h00);
      t_table(TAB_PAGE, 8'h0F, 8'h06, 8'h80, 16'h001A);
      t_table(TAB_LAST, 8'h03, 8'h05, 8'hC2, 16'h000F);
      t_table(TAB_PAGE, 8'h03, 8'h05, 8'h81, 16'h7E81);
      t_fetch(12'h305, 16'h7E81, 8'h7E);
      test_done();
   end
endmodule
`default_nettype wire
